/* File: pcp_pkg.sv */
// constants, field layout and decode helpers for the clock path control word
// assumes a 25 MHz register clock; no timing counts are needed here
package pcp_pkg;

  localparam int unsigned SYS_CLK_HZ = 25_000_000;

  // avalon byte offsets
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_CTRL_LO = 4'h0;
  localparam logic [3:0] OFS_CTRL_HI = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;

  localparam int unsigned CTRL_W = 40;
  localparam logic [39:0] CTRL_RST = 40'h00_0078_0000;
  // open bits 38:34 and 7:6 never store
  localparam logic [39:0] CTRL_WMASK = 40'h83_ffff_ff3f;

  // field positions
  localparam int unsigned DAC_PD = 39;
  localparam int unsigned BG_PD = 33;
  localparam int unsigned INT_RSET = 32;
  localparam int unsigned RISE_LSB = 29;
  localparam int unsigned FALL_LSB = 26;
  localparam int unsigned LD_EN = 25;
  localparam int unsigned LD_MODE = 24;
  localparam int unsigned RF_PD = 23;
  localparam int unsigned RF_RATIO_LSB = 21;
  localparam int unsigned DRV_PD = 20;
  localparam int unsigned DRV_SEL_LSB = 18;
  localparam int unsigned SLEW_OFF = 17;
  localparam int unsigned RF_BYP = 16;
  localparam int unsigned M_LSB = 12;
  localparam int unsigned N_LSB = 8;
  localparam int unsigned CP_POL = 5;
  localparam int unsigned CP_FPD = 4;
  localparam int unsigned CP_QPD = 3;
  localparam int unsigned CP_SCALE_LSB = 0;

  // status word bit positions
  localparam int unsigned ST_LOCKED = 0;
  localparam int unsigned ST_LAGS = 1;
  localparam int unsigned ST_PIN = 2;

  // surge currents in units of 0.05 mA
  localparam int unsigned SURGE_W = 9;
  localparam logic [8:0] RISE_LSB_UNITS = 9'h026;
  localparam logic [8:0] RISE_BASE_UNITS = 9'h098;
  localparam logic [8:0] FALL_LSB_UNITS = 9'h01b;
  localparam logic [8:0] FALL_BASE_UNITS = 9'h051;

  typedef enum logic [1:0] {
    DRV_SRC_OFF = 2'h0,
    DRV_SRC_FB = 2'h1,
    DRV_SRC_RF_OUT = 2'h2,
    DRV_SRC_RF_IN = 2'h3
  } pcp_drv_src_t;

  // built-in surge plus binary weighted extras; off kills everything
  function automatic logic [8:0] pcp_surge(input logic [2:0] bits,
      input logic [8:0] lsb_w, input logic [8:0] base, input logic off);
    logic [8:0] s;
    s = base;
    for (int i = 0; i < 3; i++) begin
      if (bits[i]) begin
        s = s + (lsb_w << i);
      end
    end
    return off ? 9'h000 : s;
  endfunction

  // field value plus one
  function automatic logic [4:0] pcp_div_ratio(input logic [3:0] f);
    return {1'b0, f} + 5'h01;
  endfunction

endpackage

/* File: pcp_cfg_if.sv */
// control word and synchronised status between register file and lock i/o
// assumes both ends on the same clock
`timescale 1ns/1ps
interface pcp_cfg_if;
  logic [39:0] ctrl;
  logic [2:0] stat;
  modport cfg_src (output ctrl, input stat);
  modport cfg_snk (input ctrl, output stat);
endinterface

/* File: pcp_lock_io.sv */
// lock indicator pin and charge pump steering from the control word
// assumes lock, lead-lag and pin inputs are asynchronous to i_sys_clk
`timescale 1ns/1ps
module pcp_lock_io (
  input wire logic i_sys_clk, // system clock
  input wire logic i_rst_n, // async reset
  input wire logic i_clk_en, // freezes state when low
  pcp_cfg_if.cfg_snk cfg, // control word in, status out
  input wire logic i_pll_locked, // detector lock level
  input wire logic i_fb_lags, // feedback lags reference
  input wire logic i_lock_pin_in, // shared pin level
  output logic o_lock_pin_out, // shared pin drive value
  output logic o_lock_pin_oe, // shared pin drive enable
  output logic o_pump_up, // pump raises control node
  output logic o_pump_dn // pump lowers control node
);
  import pcp_pkg::*;

  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic locked_s;
  logic lags_s;
  logic pump_on;
  logic raise;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
    end else if (i_clk_en) begin
      meta_q <= {i_lock_pin_in, i_fb_lags, i_pll_locked};
      sync_q <= meta_q;
    end
  end

  assign locked_s = sync_q[ST_LOCKED];
  assign lags_s = sync_q[ST_LAGS];
  assign cfg.stat = sync_q;
  // quick power-down keeps the pump running, only output is gated
  assign pump_on = !cfg.ctrl[CP_FPD] && !cfg.ctrl[CP_QPD];
  assign raise = lags_s ^ cfg.ctrl[CP_POL];

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_lock_pin_out <= 1'b0;
      o_lock_pin_oe <= 1'b0;
    end else if (i_clk_en) begin
      o_lock_pin_oe <= cfg.ctrl[LD_EN];
      o_lock_pin_out <= cfg.ctrl[LD_MODE] ? lags_s : !locked_s;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pump_up <= 1'b0;
      o_pump_dn <= 1'b0;
    end else if (i_clk_en) begin
      o_pump_up <= pump_on && raise;
      o_pump_dn <= pump_on && !raise;
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_lock_status;
    (i_clk_en && !cfg.ctrl[LD_MODE] && locked_s) |=> !o_lock_pin_out;
  endproperty
  a_lock_status: assert property (p_lock_status)
    else $error("lock pin not low while locked");

  property p_lead_lag;
    (i_clk_en && cfg.ctrl[LD_MODE]) |=> o_lock_pin_out == $past(lags_s);
  endproperty
  a_lead_lag: assert property (p_lead_lag)
    else $error("lead-lag pin value wrong");

  property p_pump_pol;
    (i_clk_en && pump_on && lags_s && !cfg.ctrl[CP_POL]) |=>
      o_pump_up && !o_pump_dn;
  endproperty
  a_pump_pol: assert property (p_pump_pol)
    else $error("pump not raising on lag");

  property p_pump_off;
    (i_clk_en && (cfg.ctrl[CP_FPD] || cfg.ctrl[CP_QPD])) |=>
      !o_pump_up && !o_pump_dn;
  endproperty
  a_pump_off: assert property (p_pump_off)
    else $error("pump output active while powered down");

endmodule

/* File: pcp_clock_path_cfg.sv */
// What this block does
// - rising surge extras of 7.6, 3.8, 1.9 mA from bits 31:29
// - falling surge extras of 5.4, 2.7, 1.35 mA from bits 28:26
// - lock enable bit drives lock indicator onto shared pin
// - lock mode: 0 gives low when locked, 1 gives lead-lag
// - rf divider power-down stops it and routes rf input to core
// - rf ratio code 11/10/01/00 gives 8/4/2/1, reset 8
// - driver power-down bit, reset one, holds driver off
// - driver source: off, feedback input, divider output, divider input
// - slew bit removes all surge, including built-in 7.6 and 4.05
// - bypass bit feeds core clock from divider input instead of output
// - reference divider M is field plus one, 1 to 16
// - feedback divider N is field plus one, 1 to 16
// - pump raises node on lag, lowers on lead; polarity inverts
// - full power-down bit stops the charge pump entirely
// - quick power-down gates only pump output buffer
// - pump current scale is field plus one, 1 to 8
//
// avalon-mm slave holding the 40-bit clock path control word
// assumes one clock domain; pins into pcp_lock_io are asynchronous
`timescale 1ns/1ps
module pcp_clock_path_cfg (
  input wire logic i_sys_clk, // 25 MHz clock
  input wire logic i_rst_n, // async reset
  input wire logic i_clk_en, // freezes state when low
  input wire logic [pcp_pkg::ADDR_W-1:0] i_avs_address, // byte address
  input wire logic i_avs_read, // read request
  input wire logic i_avs_write, // write request
  input wire logic [31:0] i_avs_writedata, // write data
  input wire logic [3:0] i_avs_byteenable, // byte lanes
  output logic [31:0] o_avs_readdata, // read data
  output logic o_avs_waitrequest, // stall
  input wire logic i_pll_locked, // detector lock level
  input wire logic i_fb_lags, // feedback lags reference
  input wire logic i_lock_pin_in, // shared pin level
  output logic o_lock_pin_out, // shared pin value
  output logic o_lock_pin_oe, // shared pin enable
  output logic [pcp_pkg::SURGE_W-1:0] o_rise_surge, // 0.05 mA units
  output logic [pcp_pkg::SURGE_W-1:0] o_fall_surge, // 0.05 mA units
  output logic o_rf_div_en, // rf divider powered
  output logic [3:0] o_rf_ratio, // rf divide ratio
  output logic o_core_clk_from_input, // core clock bypasses divider
  output logic o_drv_pd, // clock driver powered down
  output pcp_pkg::pcp_drv_src_t o_drv_sel, // driver input mux
  output logic [4:0] o_ref_div_m, // reference divide ratio
  output logic [4:0] o_fb_div_n, // feedback divide ratio
  output logic o_cp_pd, // pump full power-down
  output logic o_cp_buf_off, // pump output buffer off
  output logic [3:0] o_cp_scale, // pump current multiplier
  output logic o_pump_up, // pump raises node
  output logic o_pump_dn, // pump lowers node
  output logic o_dac_pd, // dac power-down
  output logic o_bandgap_pd, // band gap power-down
  output logic o_int_drv_rset // internal driver resistor
);
  import pcp_pkg::*;

  pcp_cfg_if cfg_bus ();

  logic [39:0] ctrl_q;
  logic [7:0] hi_shadow_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic req;
  logic accept;
  logic [31:0] be_mask;
  logic [31:0] lo_merged;
  logic [31:0] rd_mux;

  assign req = i_avs_read || i_avs_write;
  // request lands on the one cycle waitrequest is low
  assign accept = req && !wait_q;
  assign cfg_bus.ctrl = ctrl_q;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      be_mask[8*b +: 8] = {8{i_avs_byteenable[b]}};
    end
  end

  assign lo_merged = (ctrl_q[31:0] & ~be_mask) | (i_avs_writedata & be_mask);

  always_comb begin
    unique case (i_avs_address)
      OFS_CTRL_LO: rd_mux = ctrl_q[31:0];
      OFS_CTRL_HI: rd_mux = {24'h000000, ctrl_q[39:32]};
      OFS_STATUS: rd_mux = {29'h00000000, cfg_bus.stat};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // one wait cycle per request, then a single low cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_q <= 1'b1;
    end else if (i_clk_en) begin
      wait_q <= !(req && wait_q);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 32'h00000000;
    end else if (i_clk_en && i_avs_read && wait_q) begin
      rdata_q <= rd_mux;
    end
  end

  // high byte waits in a shadow until the low word commits
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hi_shadow_q <= CTRL_RST[39:32];
    end else if (i_clk_en && accept && i_avs_write &&
                 i_avs_address == OFS_CTRL_HI && i_avs_byteenable[0]) begin
      hi_shadow_q <= i_avs_writedata[7:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= CTRL_RST;
    end else if (i_clk_en && accept && i_avs_write &&
                 i_avs_address == OFS_CTRL_LO) begin
      // all five bytes land together; open bits stay zero
      ctrl_q <= {hi_shadow_q, lo_merged} & CTRL_WMASK;
    end
  end

  assign o_avs_waitrequest = wait_q;
  assign o_avs_readdata = rdata_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rise_surge <= RISE_BASE_UNITS;
      o_fall_surge <= FALL_BASE_UNITS;
    end else if (i_clk_en) begin
      o_rise_surge <= pcp_surge(ctrl_q[RISE_LSB +: 3], RISE_LSB_UNITS,
                                RISE_BASE_UNITS, ctrl_q[SLEW_OFF]);
      o_fall_surge <= pcp_surge(ctrl_q[FALL_LSB +: 3], FALL_LSB_UNITS,
                                FALL_BASE_UNITS, ctrl_q[SLEW_OFF]);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rf_div_en <= 1'b1;
      o_rf_ratio <= 4'h8;
      o_core_clk_from_input <= 1'b0;
    end else if (i_clk_en) begin
      o_rf_div_en <= !ctrl_q[RF_PD];
      o_rf_ratio <= 4'(4'h1 << ctrl_q[RF_RATIO_LSB +: 2]);
      // powered-down divider forces the alternate input path
      o_core_clk_from_input <= ctrl_q[RF_BYP] || ctrl_q[RF_PD];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_drv_pd <= 1'b1;
      o_drv_sel <= DRV_SRC_RF_OUT;
    end else if (i_clk_en) begin
      o_drv_pd <= ctrl_q[DRV_PD];
      o_drv_sel <= pcp_drv_src_t'(ctrl_q[DRV_SEL_LSB +: 2]);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ref_div_m <= 5'h01;
      o_fb_div_n <= 5'h01;
      o_cp_pd <= 1'b0;
      o_cp_buf_off <= 1'b0;
      o_cp_scale <= 4'h1;
    end else if (i_clk_en) begin
      o_ref_div_m <= pcp_div_ratio(ctrl_q[M_LSB +: 4]);
      o_fb_div_n <= pcp_div_ratio(ctrl_q[N_LSB +: 4]);
      o_cp_pd <= ctrl_q[CP_FPD];
      o_cp_buf_off <= ctrl_q[CP_QPD];
      o_cp_scale <= {1'b0, ctrl_q[CP_SCALE_LSB +: 3]} + 4'h1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dac_pd <= 1'b0;
      o_bandgap_pd <= 1'b0;
      o_int_drv_rset <= 1'b0;
    end else if (i_clk_en) begin
      o_dac_pd <= ctrl_q[DAC_PD];
      o_bandgap_pd <= ctrl_q[BG_PD];
      o_int_drv_rset <= ctrl_q[INT_RSET];
    end
  end

  pcp_lock_io u_lock_io (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .cfg(cfg_bus.cfg_snk),
    .i_pll_locked(i_pll_locked),
    .i_fb_lags(i_fb_lags),
    .i_lock_pin_in(i_lock_pin_in),
    .o_lock_pin_out(o_lock_pin_out),
    .o_lock_pin_oe(o_lock_pin_oe),
    .o_pump_up(o_pump_up),
    .o_pump_dn(o_pump_dn)
  );

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_rise_full;
    (i_clk_en && ctrl_q[RISE_LSB +: 3] == 3'h7 && !ctrl_q[SLEW_OFF]) |=>
      o_rise_surge == 9'h1a2;
  endproperty
  a_rise_full: assert property (p_rise_full)
    else $error("rising surge not 20.9 mA");

  property p_fall_full;
    (i_clk_en && ctrl_q[FALL_LSB +: 3] == 3'h7 && !ctrl_q[SLEW_OFF]) |=>
      o_fall_surge == 9'h10e;
  endproperty
  a_fall_full: assert property (p_fall_full)
    else $error("falling surge not 13.5 mA");

  property p_slew_off;
    (i_clk_en && ctrl_q[SLEW_OFF]) |=> o_rise_surge == 9'h000 &&
      o_fall_surge == 9'h000;
  endproperty
  a_slew_off: assert property (p_slew_off)
    else $error("surge present with slew bit set");

  property p_lock_oe;
    (i_clk_en && ctrl_q[LD_EN]) |=> o_lock_pin_oe;
  endproperty
  a_lock_oe: assert property (p_lock_oe)
    else $error("lock pin not driven when enabled");

  property p_rf_ratio;
    (i_clk_en && ctrl_q[RF_RATIO_LSB +: 2] == 2'h3) |=> o_rf_ratio == 4'h8;
  endproperty
  a_rf_ratio: assert property (p_rf_ratio)
    else $error("rf ratio code 11 not divide by 8");

  property p_ref_div;
    i_clk_en |=> o_ref_div_m == {1'b0, $past(ctrl_q[M_LSB +: 4])} + 5'h01;
  endproperty
  a_ref_div: assert property (p_ref_div)
    else $error("reference divider not field plus one");

  property p_core_src;
    (i_clk_en && ctrl_q[RF_PD]) |=> o_core_clk_from_input && !o_rf_div_en;
  endproperty
  a_core_src: assert property (p_core_src)
    else $error("divider power-down did not take the input path");

  sequence s_hi_write;
    i_clk_en && accept && i_avs_write && i_avs_address == OFS_CTRL_HI &&
      i_avs_byteenable[0];
  endsequence

  sequence s_lo_write;
    i_clk_en && accept && i_avs_write && i_avs_address == OFS_CTRL_LO;
  endsequence

  property p_five_byte_commit;
    s_hi_write ##[2:20] s_lo_write |=>
      ctrl_q[39:32] == ($past(hi_shadow_q) & CTRL_WMASK[39:32]);
  endproperty
  a_five_byte_commit: assert property (p_five_byte_commit)
    else $error("high byte did not commit with low word");

  property p_open_zero;
    ctrl_q[7:6] == 2'h0;
  endproperty
  a_open_zero: assert property (p_open_zero)
    else $error("open bits stored a one");

  property p_one_wait;
    (req && wait_q && i_clk_en) |=> !o_avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("waitrequest did not drop after one cycle");

  property p_drv_pd;
    i_clk_en |=> o_drv_pd == $past(ctrl_q[DRV_PD]);
  endproperty
  a_drv_pd: assert property (p_drv_pd)
    else $error("driver power-down not following its bit");

  property p_drv_off;
    (i_clk_en && ctrl_q[DRV_SEL_LSB +: 2] == 2'h0) |=>
      o_drv_sel == DRV_SRC_OFF;
  endproperty
  a_drv_off: assert property (p_drv_off)
    else $error("driver source code 00 not disconnected");

  property p_fb_div;
    i_clk_en |=> o_fb_div_n == {1'b0, $past(ctrl_q[N_LSB +: 4])} + 5'h01;
  endproperty
  a_fb_div: assert property (p_fb_div)
    else $error("feedback divider not field plus one");

  property p_cp_scale_max;
    (i_clk_en && ctrl_q[CP_SCALE_LSB +: 3] == 3'h7) |=> o_cp_scale == 4'h8;
  endproperty
  a_cp_scale_max: assert property (p_cp_scale_max)
    else $error("pump scale code 111 not times eight");

  property p_rf_byp;
    (i_clk_en && ctrl_q[RF_BYP]) |=> o_core_clk_from_input;
  endproperty
  a_rf_byp: assert property (p_rf_byp)
    else $error("bypass bit did not take the divider input");

endmodule

/* File: tb.sv */
// self-checking bench for the clock path control word slave
// assumes the avalon slave answers within a bounded number of cycles
`timescale 1ns/1ps
module tb;
  import pcp_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_clk_en = 1'b1;
  logic [3:0] i_avs_address = 4'h0;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [3:0] i_avs_byteenable = 4'hf;
  logic i_pll_locked = 1'b0;
  logic i_fb_lags = 1'b0;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest, o_lock_pin_out, o_lock_pin_oe;
  logic [8:0] o_rise_surge, o_fall_surge;
  logic o_rf_div_en, o_core_clk_from_input, o_drv_pd;
  logic [3:0] o_rf_ratio, o_cp_scale;
  pcp_drv_src_t o_drv_sel;
  logic [4:0] o_ref_div_m, o_fb_div_n;
  logic o_cp_pd, o_cp_buf_off, o_pump_up, o_pump_dn;
  logic o_dac_pd, o_bandgap_pd, o_int_drv_rset;
  // shared pin: pulled high unless the block drives it
  wire i_lock_pin_in = o_lock_pin_oe ? o_lock_pin_out : 1'b1;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [39:0] cw;
  logic [31:0] q;
  logic [8:0] er, ef;

  pcp_clock_path_cfg uut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_pll_locked(i_pll_locked), .i_fb_lags(i_fb_lags),
    .i_lock_pin_in(i_lock_pin_in), .o_lock_pin_out(o_lock_pin_out),
    .o_lock_pin_oe(o_lock_pin_oe), .o_rise_surge(o_rise_surge),
    .o_fall_surge(o_fall_surge), .o_rf_div_en(o_rf_div_en),
    .o_rf_ratio(o_rf_ratio), .o_core_clk_from_input(o_core_clk_from_input),
    .o_drv_pd(o_drv_pd), .o_drv_sel(o_drv_sel), .o_ref_div_m(o_ref_div_m),
    .o_fb_div_n(o_fb_div_n), .o_cp_pd(o_cp_pd), .o_cp_buf_off(o_cp_buf_off),
    .o_cp_scale(o_cp_scale), .o_pump_up(o_pump_up), .o_pump_dn(o_pump_dn),
    .o_dac_pd(o_dac_pd), .o_bandgap_pd(o_bandgap_pd),
    .o_int_drv_rset(o_int_drv_rset));

  always #20 i_sys_clk = ~i_sys_clk;

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d, input logic [3:0] be, output logic [31:0] rd);
    logic w;
    @(posedge i_sys_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_byteenable <= be;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    do begin
      @(posedge i_sys_clk);
      w = o_avs_waitrequest;
      rd = o_avs_readdata;
    end while (w !== 1'b0);
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask

  // decoded outputs lag the committed word by one edge
  task automatic settle(input int n);
    repeat (n) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
  endtask

  // high byte to shadow first, low word commits both; open bits kept 0
  task automatic put(input logic [39:0] w);
    bus(1'b1, OFS_CTRL_HI, {24'h0, w[39:32]}, 4'hf, q);
    bus(1'b1, OFS_CTRL_LO, w[31:0] & 32'hffff_ff3f, 4'hf, q);
    settle(2);
  endtask

  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    settle(1);
    chk(o_rise_surge, 40'h098);
    chk(o_fall_surge, 40'h051);
    chk(o_rf_div_en, 40'h1);
    chk(o_rf_ratio, 40'h8);
    chk(o_drv_pd, 40'h1);
    chk(o_drv_sel, 40'h2);
    chk({o_ref_div_m, o_fb_div_n}, 40'h21);
    chk({o_cp_pd, o_cp_buf_off, o_cp_scale}, 40'h1);
    chk(o_lock_pin_oe, 40'h0);
    bus(1'b0, OFS_CTRL_LO, 32'h0, 4'hf, q);
    chk(q, 40'h0078_0000);
    cw = 40'h00_0078_0000;
    // surge extras, every code, then slew off
    for (int i = 0; i < 8; i++) begin
      cw[31:26] = {i[2:0], i[2:0]};
      put(cw);
      er = 9'h098 + (i[2] ? 9'h098 : 9'h000) + (i[1] ? 9'h04c : 9'h000)
        + (i[0] ? 9'h026 : 9'h000);
      ef = 9'h051 + (i[2] ? 9'h06c : 9'h000) + (i[1] ? 9'h036 : 9'h000)
        + (i[0] ? 9'h01b : 9'h000);
      chk(o_rise_surge, er);
      chk(o_fall_surge, ef);
    end
    cw[17] = 1'b1;
    put(cw);
    chk({o_rise_surge, o_fall_surge}, 40'h0);
    cw[17] = 1'b0;
    // divider ratio and driver source codes
    for (int i = 0; i < 4; i++) begin
      cw[22:21] = i[1:0];
      cw[19:18] = i[1:0];
      put(cw);
      chk(o_rf_ratio, 40'h1 << i);
      chk(o_drv_sel, i);
    end
    cw[20] = 1'b0;
    cw[16] = 1'b1;
    put(cw);
    chk(o_drv_pd, 40'h0);
    chk({o_rf_div_en, o_core_clk_from_input}, 40'h3);
    cw[16] = 1'b0;
    cw[23] = 1'b1;
    put(cw);
    chk({o_rf_div_en, o_core_clk_from_input}, 40'h1);
    cw[23] = 1'b0;
    put(cw);
    chk(o_core_clk_from_input, 40'h0);
    // input dividers, every field value, and pump scale
    for (int i = 0; i < 16; i++) begin
      cw[15:8] = {i[3:0], 4'hf - i[3:0]};
      cw[2:0] = i[2:0];
      put(cw);
      chk(o_ref_div_m, i + 1);
      chk(o_fb_div_n, 16 - i);
      chk(o_cp_scale, i[2:0] + 1);
    end
    // pump steering, polarity and power-downs
    @(posedge i_sys_clk);
    i_fb_lags <= 1'b1;
    settle(4);
    chk({o_pump_up, o_pump_dn}, 40'h2);
    cw[5] = 1'b1;
    put(cw);
    chk({o_pump_up, o_pump_dn}, 40'h1);
    cw[4] = 1'b1;
    put(cw);
    chk({o_cp_pd, o_pump_up, o_pump_dn}, 40'h4);
    cw[4:3] = 2'h1;
    put(cw);
    chk({o_cp_pd, o_cp_buf_off, o_pump_up, o_pump_dn}, 40'h4);
    cw[5:3] = 3'h0;
    @(posedge i_sys_clk);
    i_fb_lags <= 1'b0;
    put(cw);
    settle(3);
    chk({o_pump_up, o_pump_dn}, 40'h1);
    // lock indicator in both modes
    cw[25] = 1'b1;
    put(cw);
    chk({o_lock_pin_oe, o_lock_pin_out}, 40'h3);
    @(posedge i_sys_clk);
    i_pll_locked <= 1'b1;
    settle(4);
    chk({o_lock_pin_oe, o_lock_pin_out}, 40'h2);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hf, q);
    chk(q, 40'h1);
    cw[24] = 1'b1;
    @(posedge i_sys_clk);
    i_fb_lags <= 1'b1;
    put(cw);
    settle(3);
    chk(o_lock_pin_out, 40'h1);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hf, q);
    chk(q, 40'h7);
    cw[25:24] = 2'h0;
    put(cw);
    chk(o_lock_pin_oe, 40'h0);
    // high byte alone stays in the shadow until the low word lands
    bus(1'b1, OFS_CTRL_HI, 32'h83, 4'hf, q);
    settle(2);
    chk({o_dac_pd, o_bandgap_pd, o_int_drv_rset}, 40'h0);
    bus(1'b0, OFS_CTRL_HI, 32'h0, 4'hf, q);
    chk(q, 40'h0);
    bus(1'b1, OFS_CTRL_LO, cw[31:0], 4'hf, q);
    settle(2);
    chk({o_dac_pd, o_bandgap_pd, o_int_drv_rset}, 40'h7);
    bus(1'b0, OFS_CTRL_HI, 32'h0, 4'hf, q);
    chk(q, 40'h83);
    // byte lane merge, unmapped place
    bus(1'b1, OFS_CTRL_LO, 32'hffff_ff05, 4'h1, q);
    bus(1'b1, 4'hc, 32'hffff_ffff, 4'hf, q);
    bus(1'b0, 4'hc, 32'h0, 4'hf, q);
    chk(q, 40'h0);
    bus(1'b0, OFS_CTRL_LO, 32'h0, 4'hf, q);
    chk(q, {cw[31:8], 8'h05});
    settle(1);
    chk(o_cp_scale, 40'h6);
    // clock enable low freezes the synchronisers and the pump steering
    @(posedge i_sys_clk);
    i_clk_en <= 1'b0;
    i_fb_lags <= 1'b0;
    settle(4);
    chk({o_pump_up, o_pump_dn}, 40'h2);
    @(posedge i_sys_clk);
    i_clk_en <= 1'b1;
    settle(4);
    chk({o_pump_up, o_pump_dn}, 40'h1);
    close_out();
  end
endmodule
